// ---- verilog/abs_addr_pkg.sv ----
package abs_addr_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_ADDR_W = 23;
	localparam int IO_ADDR_W = 16;
	localparam int PAGE_W = 7;
	localparam int SHORT_CONST_W = 16;
	localparam int EXT_W = 24;
	localparam int BIT_POS_W = 6;
	localparam int REG_SEL_W = 4;
	localparam int BLOCK_W = 4;

	// ----------------------------------------------------------------
	// extension lengths in bytes
	// ----------------------------------------------------------------
	localparam logic [1:0] SHORT_EXT_BYTES = 2'h2;
	localparam logic [1:0] FULL_EXT_BYTES = 2'h3;
	localparam logic [1:0] IO_EXT_BYTES = 2'h2;

	// ----------------------------------------------------------------
	// register-bit targets: 0-3 accumulators, 4-11 aux, 12-15 temp
	// ----------------------------------------------------------------
	localparam logic [REG_SEL_W-1:0] FIRST_AUX_REG = 4'h4;
	localparam logic [BIT_POS_W:0] ACC_BITS = 7'h28;
	localparam logic [BIT_POS_W:0] WORD_BITS = 7'h10;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_ADDR_W-1:0] DATA_ADDR_RESET = 23'h0;
	localparam logic [IO_ADDR_W-1:0] IO_ADDR_RESET = 16'h0;

	typedef enum logic [1:0] {
		MODE_SHORT = 2'b00,
		MODE_FULL = 2'b01,
		MODE_IO = 2'b10
	} addr_mode_t;

	typedef enum logic [2:0] {
		OP_SINGLE = 3'b000,
		OP_LONG = 3'b001,
		OP_DUAL = 3'b010,
		OP_COEF = 3'b011,
		OP_BIT = 3'b100
	} operand_class_t;

	typedef enum logic [1:0] {
		SPACE_DATA = 2'b00,
		SPACE_MMR = 2'b01,
		SPACE_IO = 2'b10
	} space_t;

endpackage

// ---- verilog/extension_collector.sv ----
`timescale 1ns/1ns
// gathers instruction extension bytes, most significant byte first
module extension_collector #(
	parameter int VALUE_W = 24
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// control
	input wire logic clear,
	input wire logic [1:0] byte_target,
	// byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	// result
	output logic [VALUE_W-1:0] value,
	output logic done
);

	logic [1:0] count;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count <= 2'h0;
			value <= '0;
		end else if (clear) begin
			count <= 2'h0;
			value <= '0;
		end else if (byte_valid && !done) begin
			count <= count + 2'h1;
			value <= {value[VALUE_W-9:0], byte_data};
		end
	end

	// done pulses once, set on the same edge that the last byte lands in value
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			done <= 1'b0;
		else
			done <= !clear && byte_valid && !done
				&& (count + 2'h1 == byte_target);
	end

endmodule

// ---- verilog/absolute_address_generator.sv ----
`timescale 1ns/1ns
// Overview of operation
// [RULE1] short mode address is main page high register above 16-bit constant
// [RULE2] short mode constant comes from a two-byte extension
// [RULE3] instructions with an address extension are never paired in parallel
// [RULE4] full mode uses a 23-bit constant as the whole data address
// [RULE5] full mode reads three extension bytes, drops the top bit
// [RULE6] I/O mode uses a 16-bit constant as the whole I/O address
// [RULE7] single-word operand moves one 16-bit word to data, I/O or mmr
// [RULE8] long-word operand moves 32 bits, data or mmr only, never I/O
// [RULE9] dual operand makes two independent 16-bit data accesses
// [RULE10] coefficient operand reads one 16-bit word from data memory only
// [RULE11] register-bit operand picks one or two adjacent bits of a register
// [RULE12] register-bit operand accepted only on bit test/set/clear/complement
// [RULE13] dual access takes one cycle only for dual RAM or separate blocks
// [RULE14] I/O mode address comes from a two-byte extension
module absolute_address_generator (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// instruction request
	input wire logic instr_valid,
	input wire abs_addr_pkg::addr_mode_t addr_mode,
	input wire abs_addr_pkg::operand_class_t operand_class,
	input wire abs_addr_pkg::space_t space_sel,
	input wire logic parallel_req,
	input wire logic bit_instr,
	input wire logic [abs_addr_pkg::PAGE_W-1:0] main_page_high_reg,
	// extension bytes
	input wire logic ext_valid,
	input wire logic [7:0] ext_byte,
	// register-bit operand
	input wire logic [abs_addr_pkg::REG_SEL_W-1:0] bit_reg_sel,
	input wire logic [abs_addr_pkg::BIT_POS_W-1:0] bit_pos,
	input wire logic bit_pair,
	// dual operand pair
	input wire logic [abs_addr_pkg::DATA_ADDR_W-1:0] dual_x_addr,
	input wire logic [abs_addr_pkg::DATA_ADDR_W-1:0] dual_y_addr,
	input wire logic x_in_dual_access_ram,
	input wire logic y_in_dual_access_ram,
	input wire logic [abs_addr_pkg::BLOCK_W-1:0] x_ram_block,
	input wire logic [abs_addr_pkg::BLOCK_W-1:0] y_ram_block,
	// status
	output logic ready,
	output logic reject,
	output logic parallel_ok,
	// memory access
	output logic access_valid,
	output abs_addr_pkg::space_t access_space,
	output logic access_long,
	output logic [abs_addr_pkg::DATA_ADDR_W-1:0] data_addr,
	output logic [abs_addr_pkg::IO_ADDR_W-1:0] io_addr,
	output logic second_valid,
	output logic [abs_addr_pkg::DATA_ADDR_W-1:0] second_addr,
	// register-bit access
	output logic bit_valid,
	output logic [abs_addr_pkg::REG_SEL_W-1:0] bit_reg,
	output logic [abs_addr_pkg::BIT_POS_W-1:0] bit_first,
	output logic bit_two
);
	import abs_addr_pkg::*;

	// ----------------------------------------------------------------
	// state and captured request
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXT = 2'b01,
		ST_SECOND = 2'b10
	} state_t;

	state_t state;
	addr_mode_t mode_q;
	operand_class_t class_q;
	space_t space_q;
	logic [PAGE_W-1:0] page_q;
	logic [DATA_ADDR_W-1:0] y_addr_q;

	logic [EXT_W-1:0] ext_value;
	logic ext_done;
	logic [1:0] ext_target;
	logic accept;
	logic bad;
	logic needs_ext;
	logic split_dual;
	logic [BIT_POS_W:0] bit_end;
	logic [BIT_POS_W:0] bit_limit;
	space_t req_space;

	assign accept = instr_valid && state == ST_IDLE;
	assign needs_ext = operand_class != OP_DUAL && operand_class != OP_BIT;

	// length follows the mode captured at accept, not the live mode bus
	always_comb begin
		unique case (mode_q)
		MODE_FULL: ext_target = FULL_EXT_BYTES; // see [RULE5]
		MODE_IO: ext_target = IO_EXT_BYTES; // see [RULE14]
		default: ext_target = SHORT_EXT_BYTES; // see [RULE2]
		endcase
	end

	// I/O mode forces I/O space; otherwise the caller picks data or mmr
	assign req_space = addr_mode == MODE_IO ? SPACE_IO : space_sel;

	// shared ports would collide; run x and y in successive cycles
	assign split_dual = !(x_in_dual_access_ram && y_in_dual_access_ram)
		&& (x_in_dual_access_ram || y_in_dual_access_ram
		|| x_ram_block == y_ram_block); // see [RULE13]

	assign bit_end = {1'b0, bit_pos} + {6'h0, bit_pair};
	assign bit_limit = bit_reg_sel < FIRST_AUX_REG ? ACC_BITS : WORD_BITS;

	// ----------------------------------------------------------------
	// legality of a request
	// ----------------------------------------------------------------
	always_comb begin
		bad = 1'b0;
		if (needs_ext && parallel_req)
			bad = 1'b1; // see [RULE3]
		if (needs_ext && addr_mode != MODE_FULL && addr_mode != MODE_IO
			&& addr_mode != MODE_SHORT)
			bad = 1'b1;
		if (needs_ext && req_space == SPACE_IO && space_sel != SPACE_DATA
			&& addr_mode != MODE_IO)
			bad = 1'b1;
		if (operand_class == OP_LONG && req_space == SPACE_IO)
			bad = 1'b1; // see [RULE8]
		if (operand_class == OP_COEF && req_space != SPACE_DATA)
			bad = 1'b1; // see [RULE10]
		if (operand_class == OP_BIT && !bit_instr)
			bad = 1'b1; // see [RULE12]
		if (operand_class != OP_BIT && bit_instr)
			bad = 1'b1; // see [RULE12]
		if (operand_class == OP_BIT && bit_end >= bit_limit)
			bad = 1'b1; // see [RULE11]
	end

	// ----------------------------------------------------------------
	// extension bytes
	// ----------------------------------------------------------------
	extension_collector #(
		.VALUE_W(EXT_W)
	) u_ext (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clear(accept),
		.byte_target(ext_target),
		.byte_valid(ext_valid && state == ST_EXT),
		.byte_data(ext_byte),
		.value(ext_value),
		.done(ext_done)
	);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
			ST_IDLE: begin
				if (accept && !bad && needs_ext)
					state <= ST_EXT;
				else if (accept && !bad && operand_class == OP_DUAL
					&& split_dual)
					state <= ST_SECOND;
			end
			ST_EXT: begin
				if (ext_done)
					state <= ST_IDLE;
			end
			ST_SECOND: state <= ST_IDLE;
			default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_SHORT;
			class_q <= OP_SINGLE;
			space_q <= SPACE_DATA;
			page_q <= '0;
			y_addr_q <= DATA_ADDR_RESET;
		end else if (accept) begin
			mode_q <= addr_mode;
			class_q <= operand_class;
			space_q <= req_space;
			page_q <= main_page_high_reg;
			y_addr_q <= dual_y_addr;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ready <= 1'b0;
			reject <= 1'b0;
			parallel_ok <= 1'b0;
		end else begin
			ready <= state == ST_IDLE && !accept
				|| state == ST_EXT && ext_done
				|| state == ST_SECOND;
			reject <= accept && bad;
			if (accept)
				parallel_ok <= !needs_ext; // see [RULE3]
		end
	end

	// ----------------------------------------------------------------
	// address outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			access_valid <= 1'b0;
			access_space <= SPACE_DATA;
			access_long <= 1'b0;
			data_addr <= DATA_ADDR_RESET;
			io_addr <= IO_ADDR_RESET;
			second_valid <= 1'b0;
			second_addr <= DATA_ADDR_RESET;
		end else begin
			access_valid <= 1'b0;
			second_valid <= 1'b0;
			if (state == ST_EXT && ext_done) begin
				access_valid <= 1'b1; // see [RULE7]
				access_space <= space_q;
				access_long <= class_q == OP_LONG; // see [RULE8]
				unique case (mode_q)
				MODE_FULL:
					data_addr <= ext_value[DATA_ADDR_W-1:0]; // see [RULE4]
				MODE_IO:
					io_addr <= ext_value[IO_ADDR_W-1:0]; // see [RULE6]
				default:
					data_addr <= {page_q,
						ext_value[SHORT_CONST_W-1:0]}; // see [RULE1]
				endcase
			end else if (accept && !bad && operand_class == OP_DUAL) begin
				access_valid <= 1'b1; // see [RULE9]
				access_space <= SPACE_DATA;
				access_long <= 1'b0;
				data_addr <= dual_x_addr;
				second_valid <= !split_dual; // see [RULE13]
				second_addr <= dual_y_addr;
			end else if (state == ST_SECOND) begin
				second_valid <= 1'b1; // see [RULE13]
				second_addr <= y_addr_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// register-bit outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bit_valid <= 1'b0;
			bit_reg <= '0;
			bit_first <= '0;
			bit_two <= 1'b0;
		end else begin
			bit_valid <= accept && !bad && operand_class == OP_BIT;
			if (accept && !bad && operand_class == OP_BIT) begin
				bit_reg <= bit_reg_sel; // see [RULE11]
				bit_first <= bit_pos;
				bit_two <= bit_pair;
			end
		end
	end

endmodule

// ---- sim/absolute_address_generator_chk.sv ----
`timescale 1ns/1ns
module absolute_address_generator_chk
	import abs_addr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// instruction request
	input wire logic instr_valid,
	input wire addr_mode_t addr_mode,
	input wire operand_class_t operand_class,
	input wire space_t space_sel,
	input wire logic parallel_req,
	input wire logic bit_instr,
	input wire logic [PAGE_W-1:0] main_page_high_reg,
	// extension bytes
	input wire logic ext_valid,
	input wire logic [7:0] ext_byte,
	// dual operand pair
	input wire logic [DATA_ADDR_W-1:0] dual_x_addr,
	input wire logic [DATA_ADDR_W-1:0] dual_y_addr,
	input wire logic x_in_dual_access_ram,
	input wire logic y_in_dual_access_ram,
	input wire logic [BLOCK_W-1:0] x_ram_block,
	input wire logic [BLOCK_W-1:0] y_ram_block,
	// status and access
	input wire logic ready,
	input wire logic reject,
	input wire logic access_valid,
	input wire space_t access_space,
	input wire logic [DATA_ADDR_W-1:0] data_addr,
	input wire logic [IO_ADDR_W-1:0] io_addr,
	input wire logic second_valid,
	input wire logic [DATA_ADDR_W-1:0] second_addr,
	input wire logic bit_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire take = ready && instr_valid;
	wire ext_cls = operand_class inside {OP_SINGLE, OP_LONG, OP_COEF};
	sequence s_single(addr_mode_t m);
		take && operand_class == OP_SINGLE && addr_mode == m && !parallel_req
			&& !bit_instr && space_sel == SPACE_DATA;
	endsequence
	sequence s_dual;
		take && operand_class == OP_DUAL && !parallel_req && !bit_instr;
	endsequence
	// the last byte is counted one edge, access_valid rises the next
	property p_short;
		logic [PAGE_W-1:0] pg;
		logic [7:0] hi, lo;
		(s_single(MODE_SHORT), pg = main_page_high_reg) ##1
			(ext_valid, hi = ext_byte) ##1 (ext_valid, lo = ext_byte)
			|=> ##1 access_valid && data_addr == {pg, hi, lo};
	endproperty
	property p_full;
		logic [7:0] b2, b1, b0;
		s_single(MODE_FULL) ##1 (ext_valid, b2 = ext_byte) ##1
			(ext_valid, b1 = ext_byte) ##1 (ext_valid, b0 = ext_byte)
			|=> ##1 access_valid && data_addr == {b2[6:0], b1, b0};
	endproperty
	property p_io;
		logic [7:0] hi, lo;
		s_single(MODE_IO) ##1 (ext_valid, hi = ext_byte) ##1
			(ext_valid, lo = ext_byte) |=> ##1 access_valid
			&& access_space == SPACE_IO && io_addr == {hi, lo};
	endproperty
	a_short_addr: assert property (p_short)
		else $error("short mode address wrong");
	a_full_addr: assert property (p_full)
		else $error("full mode address wrong");
	a_io_addr: assert property (p_io)
		else $error("io mode address wrong");
	a_ext_nopair: assert property (
		take && ext_cls && parallel_req |=> reject && !access_valid)
		else $error("paired extension taken");
	a_long_noio: assert property (
		take && operand_class == OP_LONG && addr_mode == MODE_IO
		|=> reject) else $error("long io taken");
	a_coef_data: assert property (
		take && operand_class == OP_COEF && space_sel == SPACE_MMR
		|=> reject) else $error("coef mmr taken");
	a_bit_only: assert property (
		take && (operand_class == OP_BIT) != bit_instr
		|=> reject && !bit_valid) else $error("bit operand mismatch taken");
	a_dual_one: assert property (
		s_dual ##0 (x_in_dual_access_ram && y_in_dual_access_ram)
		|=> access_valid && second_valid
		&& data_addr == $past(dual_x_addr)
		&& second_addr == $past(dual_y_addr))
		else $error("dual access not in one cycle");
	a_dual_split: assert property (
		s_dual ##0 (!x_in_dual_access_ram && !y_in_dual_access_ram
		&& x_ram_block == y_ram_block)
		|=> access_valid && !second_valid ##1 second_valid)
		else $error("same block dual not split");
endmodule

// ---- sim/mem_side_model.sv ----
`timescale 1ns/1ns
// far side has no wait states, so it only tallies what arrives
module mem_side_model
	import abs_addr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic access_valid,
	input wire space_t access_space,
	output int n_mem,
	output int n_io
);
	initial begin
		n_mem = 0;
		n_io = 0;
	end
	always @(posedge clk_sys) begin
		if (access_valid && access_space == SPACE_IO)
			n_io <= n_io + 1;
		else if (access_valid)
			n_mem <= n_mem + 1;
	end
endmodule

// ---- sim/absolute_address_generator_bench.sv ----
`timescale 1ns/1ns
module absolute_address_generator_bench;
	import abs_addr_pkg::*;
	logic clk_sys, resetn, instr_valid, parallel_req, bit_instr, ext_valid;
	addr_mode_t addr_mode;
	operand_class_t operand_class;
	space_t space_sel, access_space;
	logic [PAGE_W-1:0] main_page_high_reg;
	logic [7:0] ext_byte;
	logic [REG_SEL_W-1:0] bit_reg_sel, bit_reg;
	logic [BIT_POS_W-1:0] bit_pos, bit_first;
	logic bit_pair, x_in_dual_access_ram, y_in_dual_access_ram, bit_two;
	logic [DATA_ADDR_W-1:0] dual_x_addr, dual_y_addr, data_addr, second_addr;
	logic [BLOCK_W-1:0] x_ram_block, y_ram_block;
	logic ready, reject, parallel_ok, access_valid, access_long;
	logic second_valid, bit_valid;
	logic [IO_ADDR_W-1:0] io_addr;
	int n_mem, n_io, mismatches, checked, cycles;
	absolute_address_generator i_dut (.*);
	mem_side_model i_mem (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic chk1(string what, logic exp, logic got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic chk23(string what, logic [22:0] exp, logic [22:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic req(operand_class_t c, addr_mode_t m, space_t s,
		logic par, logic bi);
		for (int i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk_sys);
		chk1("ready", 1'b1, ready);
		operand_class = c;
		addr_mode = m;
		space_sel = s;
		parallel_req = par;
		bit_instr = bi;
		instr_valid = 1'b1;
		@(negedge clk_sys);
		instr_valid = 1'b0;
	endtask
	task automatic send(int n, logic [23:0] v);
		for (int i = n - 1; i >= 0; i--) begin
			ext_valid = 1'b1;
			ext_byte = v[8*i +: 8];
			@(negedge clk_sys);
		end
		ext_valid = 1'b0;
	endtask
	// pulses last one cycle, so sample every cycle of the window
	task automatic watch(output logic rj, output logic av, output logic bv);
		{rj, av, bv} = 3'h0;
		repeat (4) begin
			rj = rj | reject;
			av = av | access_valid;
			bv = bv | bit_valid;
			@(negedge clk_sys);
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_ext(operand_class_t c, addr_mode_t m, space_t s, int n,
		logic [23:0] v, logic [22:0] exp);
		logic rj, av, bv;
		int m0;
		space_t sp;
		m0 = n_mem + n_io;
		sp = m == MODE_IO ? SPACE_IO : s;
		req(c, m, s, 1'b0, 1'b0);
		send(n, v);
		watch(rj, av, bv);
		chk1("access", 1'b1, av);
		chk1("no_reject", 1'b0, rj);
		chk23("count", 23'(m0 + 1), 23'(n_mem + n_io));
		chk1("pair_ok", 1'b0, parallel_ok);
		chk1("long", c == OP_LONG, access_long);
		chk23("space", 23'(sp), 23'(access_space));
		if (m == MODE_IO)
			chk23("io_addr", exp, 23'(io_addr));
		else
			chk23("data_addr", exp, data_addr);
	endtask
	task automatic t_refuse(operand_class_t c, addr_mode_t m, space_t s,
		logic par, logic bi);
		logic rj, av, bv;
		req(c, m, s, par, bi);
		watch(rj, av, bv);
		chk1("reject", 1'b1, rj);
		chk1("no_access", 1'b0, av | bv);
	endtask
	task automatic t_bit(logic [3:0] sel, logic [5:0] pos, logic pr, logic ok);
		logic rj, av, bv;
		bit_reg_sel = sel;
		bit_pos = pos;
		bit_pair = pr;
		req(OP_BIT, MODE_SHORT, SPACE_DATA, 1'b0, 1'b1);
		watch(rj, av, bv);
		chk1("bit_valid", ok, bv);
		chk1("bit_reject", !ok, rj);
		if (ok)
			chk23("bit_sel", 23'({sel, pos, pr}),
				23'({bit_reg, bit_first, bit_two}));
	endtask
	task automatic t_dual(logic xd, logic yd, logic [3:0] xb, logic [3:0] yb,
		logic split);
		{x_in_dual_access_ram, y_in_dual_access_ram} = {xd, yd};
		{x_ram_block, y_ram_block} = {xb, yb};
		dual_x_addr = {xb, 19'h1a2b3};
		dual_y_addr = {yb, 19'h54c6d};
		req(OP_DUAL, MODE_SHORT, SPACE_DATA, 1'b0, 1'b0);
		chk1("first", 1'b1, access_valid);
		chk1("second_now", !split, second_valid);
		chk23("x_addr", dual_x_addr, data_addr);
		chk1("pair_ok", 1'b1, parallel_ok);
		if (split) @(negedge clk_sys);
		chk1("second", 1'b1, second_valid);
		chk23("y_addr", dual_y_addr, second_addr);
		@(negedge clk_sys);
	endtask
	initial begin
		{resetn, instr_valid, parallel_req, bit_instr, ext_valid} = 5'h0;
		{bit_pair, x_in_dual_access_ram, y_in_dual_access_ram} = 3'h0;
		addr_mode = MODE_SHORT;
		operand_class = OP_SINGLE;
		space_sel = SPACE_DATA;
		{ext_byte, bit_reg_sel, bit_pos, x_ram_block, y_ram_block} = 26'h0;
		{dual_x_addr, dual_y_addr} = 46'h0;
		mismatches = 0;
		checked = 0;
		main_page_high_reg = 7'h7f;
		repeat (6) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		t_ext(OP_SINGLE, MODE_SHORT, SPACE_DATA, 2,
			24'hffff, 23'h7fffff);
		main_page_high_reg = 7'h01;
		t_ext(OP_COEF, MODE_SHORT, SPACE_DATA, 2,
			24'h0000, 23'h010000);
		t_ext(OP_LONG, MODE_FULL, SPACE_MMR, 3,
			24'hd2b4c6, 23'h52b4c6);
		t_ext(OP_SINGLE, MODE_FULL, SPACE_DATA, 3,
			24'h812345, 23'h012345);
		t_ext(OP_SINGLE, MODE_IO, SPACE_DATA, 2,
			24'h8001, 23'h008001);
		t_refuse(OP_SINGLE, MODE_SHORT, SPACE_DATA,
			1'b1, 1'b0);
		t_refuse(OP_LONG, MODE_IO, SPACE_DATA,
			1'b0, 1'b0);
		t_refuse(OP_COEF, MODE_SHORT, SPACE_MMR,
			1'b0, 1'b0);
		t_refuse(OP_COEF, MODE_IO, SPACE_DATA,
			1'b0, 1'b0);
		t_refuse(OP_BIT, MODE_SHORT, SPACE_DATA,
			1'b0, 1'b0);
		t_refuse(OP_SINGLE, MODE_SHORT, SPACE_DATA,
			1'b0, 1'b1);
		t_bit(4'h0, 6'd38, 1'b1, 1'b1);
		t_bit(4'h0, 6'd39, 1'b1, 1'b0);
		t_bit(4'h3, 6'd39, 1'b0, 1'b1);
		t_bit(4'h4, 6'd15, 1'b0, 1'b1);
		t_bit(4'hb, 6'd15, 1'b1, 1'b0);
		t_bit(4'hf, 6'd14, 1'b1, 1'b1);
		t_dual(1'b1, 1'b1, 4'h0, 4'h0, 1'b0);
		t_dual(1'b0, 1'b0, 4'h2, 4'h5, 1'b0);
		t_dual(1'b0, 1'b0, 4'h3, 4'h3, 1'b1);
		t_dual(1'b1, 1'b0, 4'h3, 4'h3, 1'b1);
		end_sim();
	end
endmodule
bind absolute_address_generator absolute_address_generator_chk i_chk (.*);
